// >>> uec_pkg.sv
package uec_pkg;
  // Count range and reset values
  localparam int CNT_W = 24;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_ONE = 24'h000001;
  localparam logic [23:0] CMP_RESET = 24'hFFFFFF;
  localparam logic [23:0] START_RESET = 24'h000000;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILT_TIME_NS = 20000;
  localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_W = 11;
  localparam int UPD_TIME_NS = 500000;
  localparam int UPD_CYC = UPD_TIME_NS / CLK_PERIOD_NS;
  localparam int UPD_W = 17;
  localparam int MAX_IN_FREQ_HZ = 10000;
endpackage

// >>> uec_filter.sv
`timescale 1ns/1ps
module uec_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [uec_pkg::FILT_W-1:0] cnt;
  } uec_filt_t;

  localparam logic [uec_pkg::FILT_W-1:0] FILT_END = uec_pkg::FILT_W'(uec_pkg::FILT_CYC - 1);

  uec_filt_t st_reg;
  uec_filt_t st_next;

  // Level accepted only after holding steady for the filter time; shorter spikes vanish
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
    if (st_reg.s2 == st_reg.lvl)
    begin
      st_next.cnt = '0;
    end
    else if (st_reg.cnt == FILT_END)
    begin
      st_next.lvl = st_reg.s2;
      st_next.cnt = '0;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign dout = st_reg.lvl;
endmodule

// >>> uec_counter.sv
`timescale 1ns/1ps
module uec_counter #(
  parameter int UPD_CYCLES = uec_pkg::UPD_CYC
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CNT_IN,
  input wire logic EDGE_FALL,
  input wire logic DIR_DOWN,
  input wire logic IRQ_EN,
  input wire logic [uec_pkg::CNT_W-1:0] PRESET_VAL,
  input wire logic LOAD_REQ,
  input wire logic RUN,
  output logic [uec_pkg::CNT_W-1:0] COUNT_VAL,
  output logic COUNT_EN,
  output logic IRQ
);
  typedef struct packed {
    logic in_prev;
    logic run_prev;
    logic load_prev;
    logic pend;
    logic [uec_pkg::CNT_W-1:0] pend_val;
    logic [uec_pkg::CNT_W-1:0] cmp;
    logic [uec_pkg::CNT_W-1:0] start;
    logic [uec_pkg::CNT_W-1:0] count;
    logic [uec_pkg::CNT_W-1:0] shown;
    logic [uec_pkg::UPD_W-1:0] upd_cnt;
    logic irq;
  } uec_state_t;

  localparam logic [uec_pkg::UPD_W-1:0] UPD_END = uec_pkg::UPD_W'(UPD_CYCLES - 1);

  uec_state_t st_reg;
  uec_state_t st_next;
  logic filt_lvl;
  logic edge_seen;
  logic cnt_en;
  logic load_rise;
  logic run_rise;
  // Values as seen by the edge now being counted
  logic [uec_pkg::CNT_W-1:0] cmp_eff;
  logic [uec_pkg::CNT_W-1:0] start_eff;
  logic [uec_pkg::CNT_W-1:0] cnt_base;

  // Synchroniser and glitch filter ahead of edge detection
  uec_filter u_filter (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din(CNT_IN),
    .dout(filt_lvl)
  );

  // Selected edge of the filtered level, counted only while running
  assign edge_seen = EDGE_FALL ? (st_reg.in_prev & ~filt_lvl)
                               : (~st_reg.in_prev & filt_lvl);
  assign cnt_en = edge_seen & RUN;
  assign load_rise = LOAD_REQ & ~st_reg.load_prev;
  assign run_rise = RUN & ~st_reg.run_prev;

  // Pending values become live at the count edge that consumes them
  always_comb
  begin
    cmp_eff = st_reg.cmp;
    start_eff = st_reg.start;
    cnt_base = st_reg.count;
    if (st_reg.pend)
    begin
      if (DIR_DOWN)
      begin
        start_eff = st_reg.pend_val;
        cnt_base = st_reg.count + st_reg.pend_val - st_reg.start;
      end
      else
      begin
        cmp_eff = st_reg.pend_val;
      end
    end
  end

  // Next-state logic for the whole counter
  always_comb
  begin
    st_next = st_reg;
    st_next.in_prev = filt_lvl;
    st_next.run_prev = RUN;
    st_next.load_prev = LOAD_REQ;
    st_next.irq = 1'b0;
    // Load request rise captures the value as pending
    if (load_rise)
    begin
      st_next.pend = 1'b1;
      st_next.pend_val = PRESET_VAL;
    end
    if (run_rise && LOAD_REQ)
    begin
      // Start with initialisation: values apply at once, count restarts
      st_next.pend = 1'b0;
      if (DIR_DOWN)
      begin
        st_next.start = PRESET_VAL;
        st_next.count = PRESET_VAL;
      end
      else
      begin
        st_next.cmp = PRESET_VAL;
        st_next.count = uec_pkg::CNT_ZERO;
      end
    end
    else if (cnt_en)
    begin
      // Counted edge: step, wrap at the comparison or reload at zero
      st_next.pend = load_rise;
      st_next.cmp = cmp_eff;
      st_next.start = start_eff;
      if (DIR_DOWN)
      begin
        if (cnt_base <= uec_pkg::CNT_ONE)
        begin
          st_next.count = start_eff;
          st_next.irq = IRQ_EN;
        end
        else
        begin
          st_next.count = cnt_base - uec_pkg::CNT_ONE;
        end
      end
      else
      begin
        if (cnt_base + uec_pkg::CNT_ONE == cmp_eff)
        begin
          st_next.count = uec_pkg::CNT_ZERO;
          st_next.irq = IRQ_EN;
        end
        else
        begin
          st_next.count = cnt_base + uec_pkg::CNT_ONE;
        end
      end
    end
    // Periodic snapshot; software sees a value up to one period old
    if (st_reg.upd_cnt == UPD_END)
    begin
      st_next.upd_cnt = '0;
      st_next.shown = st_reg.count;
    end
    else
    begin
      st_next.upd_cnt = st_reg.upd_cnt + 1'b1;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge REF_CLK)
  begin
    if (!RSTN)
    begin
      st_reg <= '0;
      st_reg.cmp <= uec_pkg::CMP_RESET;
      st_reg.start <= uec_pkg::START_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign COUNT_VAL = st_reg.shown;
  assign COUNT_EN = cnt_en;
  assign IRQ = st_reg.irq;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  // Count enable never lasts two cycles in a row
  en_single_a: assert property (cnt_en |=> !cnt_en)
    else $error("count enable longer than one cycle");

  // Enable only on the selected edge of the filtered level
  edge_sel_a: assert property (cnt_en
    |-> (EDGE_FALL ? $fell(filt_lvl) : $rose(filt_lvl)))
    else $error("count enable without selected edge");

  // Up count advances by one on a plain edge
  up_step_a: assert property (cnt_en && !DIR_DOWN && !st_reg.pend && !run_rise
    && st_reg.count + uec_pkg::CNT_ONE != st_reg.cmp
    |=> st_reg.count == $past(st_reg.count) + uec_pkg::CNT_ONE)
    else $error("up count did not advance by one");

  // Down count falls by one on a plain edge
  down_step_a: assert property (cnt_en && DIR_DOWN && !st_reg.pend && !run_rise
    && st_reg.count > uec_pkg::CNT_ONE
    |=> st_reg.count == $past(st_reg.count) - uec_pkg::CNT_ONE)
    else $error("down count did not fall by one");

  // Count holds while no edge is counted and nothing initialises
  hold_idle_a: assert property (!cnt_en && !(run_rise && LOAD_REQ)
    |=> $stable(st_reg.count))
    else $error("count changed without an edge");

  // Interrupt only when enabled
  irq_gate_a: assert property (IRQ |-> $past(IRQ_EN))
    else $error("interrupt while disabled");

  // Up wrap at comparison returns to zero with interrupt
  up_wrap_a: assert property (cnt_en && !DIR_DOWN && !st_reg.pend && !run_rise
    && IRQ_EN && st_reg.count + uec_pkg::CNT_ONE == st_reg.cmp
    |=> IRQ && st_reg.count == uec_pkg::CNT_ZERO)
    else $error("no interrupt at comparison value");

  // Initialising start in up mode clears the count
  up_init_a: assert property (run_rise && LOAD_REQ && !DIR_DOWN
    |=> st_reg.count == uec_pkg::CNT_ZERO)
    else $error("up start did not clear count");

  // Pending comparison value used at the next edge
  pend_apply_a: assert property (cnt_en && st_reg.pend && !DIR_DOWN && !run_rise
    |=> st_reg.cmp == $past(st_reg.pend_val))
    else $error("pending comparison not applied");

  // Visible count only changes at a refresh point
  show_hold_a: assert property (st_reg.upd_cnt != UPD_END |=> $stable(COUNT_VAL))
    else $error("visible count changed between refreshes");

  // Refresh carries the live count
  show_load_a: assert property (st_reg.upd_cnt == UPD_END
    |=> COUNT_VAL == $past(st_reg.count))
    else $error("refresh did not copy count");

  // Reset leaves the comparison at the end of the count range
  cmp_reset_a: assert property ($rose(RSTN) |-> st_reg.cmp == uec_pkg::CMP_RESET)
    else $error("comparison not at end of range after reset");

  // Nothing is visible right after reset
  show_reset_a: assert property ($rose(RSTN)
    |-> COUNT_VAL == uec_pkg::CNT_ZERO && !IRQ)
    else $error("visible state not clear after reset");

  // Interrupt follows a counted edge
  irq_cause_a: assert property (IRQ |-> $past(cnt_en))
    else $error("interrupt without counted edge");

  // Interrupt lasts one cycle
  irq_once_a: assert property (IRQ |=> !IRQ)
    else $error("interrupt longer than one cycle");

  // Down count reloads the start value when it passes zero
  down_reload_a: assert property (cnt_en && DIR_DOWN && !st_reg.pend && !run_rise
    && st_reg.count <= uec_pkg::CNT_ONE
    |=> st_reg.count == $past(st_reg.start) && IRQ == $past(IRQ_EN))
    else $error("down count did not reload at zero");

  // Initialising start in down mode loads the start value
  down_init_a: assert property (run_rise && LOAD_REQ && DIR_DOWN
    |=> st_reg.count == $past(PRESET_VAL))
    else $error("down start did not load start value");

  // Load request captures the value and holds it pending
  pend_latch_a: assert property (load_rise && !run_rise
    |=> st_reg.pend && st_reg.pend_val == $past(PRESET_VAL))
    else $error("load request not captured");

  // A pending value waits for the next counted edge
  pend_keep_a: assert property (st_reg.pend && !cnt_en && !run_rise
    |=> st_reg.pend)
    else $error("pending value dropped without an edge");

  // Up count never rests on a nonzero comparison value
  up_range_a: assert property (cnt_en && !DIR_DOWN
    |=> st_reg.count != st_reg.cmp || st_reg.cmp == uec_pkg::CNT_ZERO)
    else $error("up count rests on comparison value");

  // Down count never rests on zero unless the start value is zero
  down_range_a: assert property (cnt_en && DIR_DOWN
    |=> st_reg.count != uec_pkg::CNT_ZERO || st_reg.start == uec_pkg::CNT_ZERO)
    else $error("down count rests on zero");

  up_irq_c: cover property (IRQ && !DIR_DOWN);
  down_irq_c: cover property (IRQ && DIR_DOWN);
  pend_c: cover property (cnt_en && st_reg.pend);
  fall_c: cover property (cnt_en && EDGE_FALL);
  init_c: cover property (run_rise && LOAD_REQ);
endmodule

// >>> uec_pulse_src.sv
`timescale 1ns/1ps
module uec_pulse_src (
  input wire logic clk,
  output logic pin
);
  // Line rests low between pulses, as with a pull-down on the input
  initial pin = 1'b0;

  // Each pulse gives one rise and one fall; the period is held at 10 kHz
  task automatic send(input int n, input int hi);
    repeat (n)
    begin
      @(negedge clk) pin = 1'b1;
      repeat (hi) @(negedge clk);
      pin = 1'b0;
      repeat (10000 - hi) @(negedge clk);
    end
  endtask
endmodule

// >>> uec_tb.sv
`timescale 1ns/1ps
module universal_input_edge_counter_tb;
  typedef struct packed {
    logic fall;
    logic down;
    logic irq_en;
    logic [23:0] preset;
    logic [3:0] n;
    logic [23:0] exp;
    logic [3:0] irqs;
  } uec_row_t;

  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic edge_fall = 1'b0;
  logic dir_down = 1'b0;
  logic irq_en = 1'b0;
  logic load_req = 1'b0;
  logic run = 1'b0;
  logic [23:0] preset_val = 24'h000000;
  logic cnt_in;
  logic [23:0] count_val;
  logic count_en;
  logic irq;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int n_en = 0;
  int n_irq = 0;
  // Start-up wait before run, scaled down like the refresh period
  localparam int START_WAIT = 2;
  // Up wrap, down reload, down reload with interrupt off, plain up count last
  uec_row_t rows [4] = '{
    '{1'b1, 1'b0, 1'b1, 24'h000002, 4'h3, 24'h000001, 4'h1},
    '{1'b0, 1'b1, 1'b1, 24'h000002, 4'h2, 24'h000002, 4'h1},
    '{1'b1, 1'b1, 1'b0, 24'h000001, 4'h1, 24'h000001, 4'h0},
    '{1'b0, 1'b0, 1'b1, 24'h000005, 4'h1, 24'h000001, 4'h0}};

  always #5 ref_clk = ~ref_clk;

  uec_counter #(.UPD_CYCLES(20)) dut_u (
    .REF_CLK(ref_clk), .RSTN(rstn), .CNT_IN(cnt_in), .EDGE_FALL(edge_fall),
    .DIR_DOWN(dir_down), .IRQ_EN(irq_en), .PRESET_VAL(preset_val), .LOAD_REQ(load_req),
    .RUN(run), .COUNT_VAL(count_val), .COUNT_EN(count_en), .IRQ(irq));

  uec_pulse_src src_u (.clk(ref_clk), .pin(cnt_in));

  // Tally one-cycle pulses; a stuck pulse shows up as an inflated tally
  always @(posedge ref_clk)
  begin
    cyc++;
    if (count_en === 1'b1) n_en++;
    if (irq === 1'b1) n_irq++;
    if (cyc == 101000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_num(input string what, input int exp, input int got);
    compares++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Reset, then load the preset and start with the load bit still high
  task automatic start(input uec_row_t r);
    @(negedge ref_clk) rstn = 1'b0;
    run = 1'b0;
    edge_fall = r.fall;
    dir_down = r.down;
    irq_en = r.irq_en;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    chk_val("reset count", 24'h000000, count_val);
    preset_val = r.preset;
    load_req = 1'b1;
    repeat (START_WAIT) @(negedge ref_clk);
    run = 1'b1;
    @(negedge ref_clk) load_req = 1'b0;
    n_en = 0;
    n_irq = 0;
  endtask

  task automatic end_of_test;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Table rows; the long low phase also covers filter delay and refresh
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      start(rows[i]);
      src_u.send(int'(rows[i].n), 2100);
      chk_val("count", rows[i].exp, count_val);
      chk_num("edges", int'(rows[i].n), n_en);
      chk_num("irqs", int'(rows[i].irqs), n_irq);
    end
    // A value loaded while running takes effect at the next counted edge
    @(negedge ref_clk) preset_val = 24'h000002;
    load_req = 1'b1;
    @(negedge ref_clk) load_req = 1'b0;
    src_u.send(1, 2100);
    chk_val("pending compare", 24'h000000, count_val);
    chk_num("pending irqs", 1, n_irq);
    chk_num("pending edges", 2, n_en);
    // A glitch shorter than the filter window must not count
    src_u.send(1, 500);
    chk_val("short pulse", 24'h000000, count_val);
    // Stopped counter ignores a full pulse
    @(negedge ref_clk) run = 1'b0;
    src_u.send(1, 2100);
    chk_val("stopped", 24'h000000, count_val);
    chk_num("stopped edges", 2, n_en);
    end_of_test();
  end
endmodule
